/* gfd_consts.svh */
`ifndef GFD_CONSTS_SVH
`define GFD_CONSTS_SVH
// =====================================================================
// register byte addresses
`define GFD_PIN1_CTRL_ADDR 12'h000
`define GFD_PIN2_CTRL_ADDR 12'h004
`define GFD_DEBOUNCE_CFG_ADDR 12'hc10
`define GFD_IRQ_STATUS_ADDR 12'h020
`define GFD_IRQ_MASK_ADDR 12'h024
// =====================================================================
// pin control and debounce config field positions
`define GFD_FN_LSB 0
`define GFD_FN_W 7
`define GFD_DB_BIT 8
`define GFD_ODRAIN_BIT 9
`define GFD_POL_BIT 10
`define GFD_LVL_BIT 11
`define GFD_DIR_BIT 15
`define GFD_DBTIME_LSB 12
// =====================================================================
// reset values
`define GFD_FN_RESET 7'h01
`define GFD_DBTIME_RESET 4'h1
// =====================================================================
// debounce timebase: 100 us tick; times in ticks
`define GFD_CLK_MHZ 100
`define GFD_TICK_US 100
`define GFD_TICK_CYCLES (`GFD_TICK_US * `GFD_CLK_MHZ)
// =====================================================================
// function codes
`define GFD_FN_NONE 7'h00
`define GFD_FN_LEVEL 7'h01
`define GFD_FN_INT_ONE 7'h02
`define GFD_FN_INT_TWO 7'h03
`define GFD_FN_DIV_CLK 7'h04
`define GFD_FN_LOOP1_CLK 7'h05
`define GFD_FN_LOOP2_CLK 7'h06
`define GFD_FN_PULSE_ONE 7'h08
`define GFD_FN_PULSE_TWO 7'h09
`define GFD_FN_SYSUC 7'h0a
`define GFD_FN_ASYUC 7'h0b
`define GFD_FN_LOOP1_LOCK 7'h0c
`define GFD_FN_LOOP2_LOCK 7'h0d
`define GFD_FN_LOOP1_OK 7'h0f
`define GFD_FN_LOOP2_OK 7'h10
`define GFD_FN_WSEQ 7'h15
`define GFD_FN_ADDRERR 7'h16
`define GFD_FN_RC1LK 7'h1a
`define GFD_FN_RC2LK 7'h1b
`endif

/* gfd_pkg.sv */
package gfd_pkg;
  // internal sources routable to a pin
  typedef struct packed {
    logic interrupt_line_one;
    logic interrupt_line_two;
    logic divided_system_clock_output;
    logic frequency_locked_loop_one_clk;
    logic frequency_locked_loop_two_clk;
    logic pulse_width_output_one;
    logic pulse_width_output_two;
    logic core_system_clock_underclock;
    logic asynchronous_domain_clock_underclock;
    logic frequency_locked_loop_one_lock;
    logic frequency_locked_loop_two_lock;
    logic frequency_locked_loop_one_ok;
    logic frequency_locked_loop_two_ok;
    logic write_sequencer_done;
    logic address_error;
    logic rate_converter_one_lock;
    logic rate_converter_two_lock;
  } gfd_src_t;

  typedef struct packed {
    logic pin_direction;
    logic pin_level;
    logic output_polarity_invert;
    logic output_drive_type;
    logic input_debounce_enable;
    logic [6:0] pin_function_select;
  } gfd_pin_cfg_t;

  typedef enum logic [1:0] {
    GFD_IDLE = 2'b00,
    GFD_WAIT = 2'b01,
    GFD_DONE = 2'b11
  } gfd_db_state_t;
endpackage : gfd_pkg

/* gfd_debounce.sv */
`timescale 1ns/1ps
`include "gfd_consts.svh"
module gfd_debounce
  import gfd_pkg::*;
#(
  parameter int CNT_W = 14
)(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic tick,
  input wire logic enable,
  input wire logic [CNT_W-1:0] limit,
  // pin
  input wire logic raw,
  output logic filtered
);
  initial if (CNT_W < 13) $error("gfd_debounce: CNT_W too small");

  // =====================================================================
  // stability filter
  gfd_db_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic out_q, out_d;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    out_d = out_q;
    case (st_q)
      GFD_IDLE:
      begin
        if (!enable)
        begin
          out_d = raw;
        end
        else if (raw != out_q)
        begin
          st_d = GFD_WAIT;
          cnt_d = '0;
        end
      end
      GFD_WAIT:
      begin
        // any bounce restarts the timer
        if (!enable || raw == out_q)
        begin
          st_d = GFD_IDLE;
        end
        else if (tick)
        begin
          if (cnt_q + 1'b1 >= limit)
          begin
            st_d = GFD_DONE;
          end
          cnt_d = cnt_q + 1'b1;
        end
      end
      GFD_DONE:
      begin
        out_d = raw;
        st_d = GFD_IDLE;
      end
      default: st_d = GFD_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= GFD_IDLE;
      cnt_q <= '0;
      out_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign filtered = out_q;
endmodule : gfd_debounce

/* gfd_top.sv */
// Contract
// - debounce time 4 bits, reset 1, 100us-768ms
// - per-pin debounce enable bit 8, reset on
// - seven-bit function field, reset 01h, two pins
// - 00h none; 01h level out or input
// - 02h/03h drive interrupt lines one/two
// - 04h divided clock; 05h/06h loop clocks
// - 08h/09h drive pulse-width outputs
// - 0Ah/0Bh underclocking flags
// - 0Ch/0Dh loop lock status
// - 0Fh/10h loop clock-OK flags
// - 15h write sequencer done pulse
// - 16h address error flag
// - 1Ah/1Bh rate converter lock
// - level bit 11 writes out, reads input
// - polarity bit 10 inverts output functions
// - bit 9 selects push-pull or open-drain
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`include "gfd_consts.svh"
module gfd_top
  import gfd_pkg::*;
#(
  parameter int NPINS = 2,
  parameter int TICK_CYCLES = `GFD_TICK_CYCLES
)(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // internal sources
  input wire gfd_src_t src,
  // pins
  input wire logic [NPINS-1:0] pin_in,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe,
  // interrupt
  output logic irq
);
  initial if (NPINS != 2) $error("gfd_top: exactly two pins supported");
  // the timebase counter is 16 bits wide
  initial if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) $error("gfd_top: TICK_CYCLES out of range");

  localparam int CNT_W = 14;

  // debounce time code to ticks of 100 us
  function automatic logic [CNT_W-1:0] db_ticks(input logic [3:0] code);
    case (code)
      4'h0: db_ticks = 14'd1;
      4'h1: db_ticks = 14'd15;
      4'h2: db_ticks = 14'd30;
      4'h3: db_ticks = 14'd60;
      4'h4: db_ticks = 14'd120;
      4'h5: db_ticks = 14'd240;
      4'h6: db_ticks = 14'd480;
      4'h7: db_ticks = 14'd960;
      4'h8: db_ticks = 14'd1920;
      4'h9: db_ticks = 14'd3840;
      4'ha: db_ticks = 14'd7680;
      // reserved codes fall back to the longest time
      default: db_ticks = 14'd7680;
    endcase
  endfunction : db_ticks

  // =====================================================================
  // ahb address phase capture
  logic wr_q, wr_d, rd_q, rd_d;
  logic [11:0] addr_q, addr_d;
  logic take;

  assign take = hsel && hready && htrans[1];

  always_comb
  begin
    wr_d = take && hwrite;
    rd_d = take && !hwrite;
    addr_d = take ? haddr[11:0] : addr_q;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 12'h000;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // =====================================================================
  // configuration registers
  gfd_pin_cfg_t cfg_q [NPINS];
  gfd_pin_cfg_t cfg_d [NPINS];
  logic [3:0] dbtime_q, dbtime_d;
  logic [NPINS-1:0] sts_q, sts_d, mask_q, mask_d;
  logic [NPINS-1:0] filt, filt_prev_q;
  logic [NPINS-1:0] edge_ev;

  assign edge_ev = filt ^ filt_prev_q;

  always_comb
  begin
    for (int i = 0; i < NPINS; i++)
    begin
      cfg_d[i] = cfg_q[i];
      if (wr_q && addr_q == (i == 0 ? `GFD_PIN1_CTRL_ADDR : `GFD_PIN2_CTRL_ADDR))
      begin
        cfg_d[i].pin_function_select = hwdata[`GFD_FN_LSB +: `GFD_FN_W];
        cfg_d[i].input_debounce_enable = hwdata[`GFD_DB_BIT];
        cfg_d[i].output_drive_type = hwdata[`GFD_ODRAIN_BIT];
        cfg_d[i].output_polarity_invert = hwdata[`GFD_POL_BIT];
        cfg_d[i].pin_level = hwdata[`GFD_LVL_BIT];
        cfg_d[i].pin_direction = hwdata[`GFD_DIR_BIT];
      end
    end
    dbtime_d = dbtime_q;
    if (wr_q && addr_q == `GFD_DEBOUNCE_CFG_ADDR)
    begin
      dbtime_d = hwdata[`GFD_DBTIME_LSB +: 4];
    end
    mask_d = mask_q;
    if (wr_q && addr_q == `GFD_IRQ_MASK_ADDR)
    begin
      mask_d = hwdata[NPINS-1:0];
    end
    // set wins over write-one-to-clear
    sts_d = sts_q;
    if (wr_q && addr_q == `GFD_IRQ_STATUS_ADDR)
    begin
      sts_d = sts_q & ~hwdata[NPINS-1:0];
    end
    for (int i = 0; i < NPINS; i++)
    begin
      if (cfg_q[i].pin_direction && edge_ev[i])
      begin
        sts_d[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < NPINS; i++)
      begin
        cfg_q[i] <= '{pin_direction: 1'b0, pin_level: 1'b0,
                      output_polarity_invert: 1'b0, output_drive_type: 1'b0,
                      input_debounce_enable: 1'b1,
                      pin_function_select: `GFD_FN_RESET};
      end
      dbtime_q <= `GFD_DBTIME_RESET;
      mask_q <= '0;
      sts_q <= '0;
      filt_prev_q <= '0;
    end
    else
    begin
      cfg_q <= cfg_d;
      dbtime_q <= dbtime_d;
      mask_q <= mask_d;
      sts_q <= sts_d;
      filt_prev_q <= filt;
    end
  end

  assign irq = |(sts_q & mask_q);

  // =====================================================================
  // read data, driven combinationally in the data phase
  logic [31:0] rdata;

  always_comb
  begin
    rdata = 32'h0000_0000;
    case (addr_q)
      `GFD_PIN1_CTRL_ADDR, `GFD_PIN2_CTRL_ADDR:
      begin
        for (int i = 0; i < NPINS; i++)
        begin
          if (addr_q == (i == 0 ? `GFD_PIN1_CTRL_ADDR : `GFD_PIN2_CTRL_ADDR))
          begin
            rdata[`GFD_FN_LSB +: `GFD_FN_W] = cfg_q[i].pin_function_select;
            rdata[`GFD_DB_BIT] = cfg_q[i].input_debounce_enable;
            rdata[`GFD_ODRAIN_BIT] = cfg_q[i].output_drive_type;
            rdata[`GFD_POL_BIT] = cfg_q[i].output_polarity_invert;
            // write-only when output: reads zero then
            rdata[`GFD_LVL_BIT] = cfg_q[i].pin_direction & filt[i];
            rdata[`GFD_DIR_BIT] = cfg_q[i].pin_direction;
          end
        end
      end
      `GFD_DEBOUNCE_CFG_ADDR: rdata[`GFD_DBTIME_LSB +: 4] = dbtime_q;
      `GFD_IRQ_STATUS_ADDR: rdata[NPINS-1:0] = sts_q;
      `GFD_IRQ_MASK_ADDR: rdata[NPINS-1:0] = mask_q;
      default: rdata = 32'h0000_0000;
    endcase
  end

  assign hrdata = rd_q ? rdata : 32'h0000_0000;

  // =====================================================================
  // debounce timebase
  logic [15:0] tb_q, tb_d;
  logic tick;

  assign tick = (tb_q == 16'(TICK_CYCLES - 1));

  always_comb
  begin
    tb_d = tick ? 16'h0000 : tb_q + 16'h0001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tb_q <= 16'h0000;
    end
    else
    begin
      tb_q <= tb_d;
    end
  end

  // =====================================================================
  // per-pin input filter and output routing
  logic [NPINS-1:0] drv_val, drv_en;

  for (genvar g = 0; g < NPINS; g++)
  begin : g_pin
    gfd_debounce #(.CNT_W(CNT_W)) u_db (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(tick),
      .enable(cfg_q[g].input_debounce_enable),
      .limit(db_ticks(dbtime_q)),
      .raw(pin_in[g]),
      .filtered(filt[g])
    );
  end

  always_comb
  begin
    for (int i = 0; i < NPINS; i++)
    begin
      drv_en[i] = 1'b1;
      case (cfg_q[i].pin_function_select)
        `GFD_FN_LEVEL:
        begin
          // direction set means the pin is an input
          drv_en[i] = !cfg_q[i].pin_direction;
          drv_val[i] = cfg_q[i].pin_level;
        end
        `GFD_FN_INT_ONE: drv_val[i] = src.interrupt_line_one;
        `GFD_FN_INT_TWO: drv_val[i] = src.interrupt_line_two;
        `GFD_FN_DIV_CLK: drv_val[i] = src.divided_system_clock_output;
        `GFD_FN_LOOP1_CLK: drv_val[i] = src.frequency_locked_loop_one_clk;
        `GFD_FN_LOOP2_CLK: drv_val[i] = src.frequency_locked_loop_two_clk;
        `GFD_FN_PULSE_ONE: drv_val[i] = src.pulse_width_output_one;
        `GFD_FN_PULSE_TWO: drv_val[i] = src.pulse_width_output_two;
        `GFD_FN_SYSUC: drv_val[i] = src.core_system_clock_underclock;
        `GFD_FN_ASYUC: drv_val[i] = src.asynchronous_domain_clock_underclock;
        `GFD_FN_LOOP1_LOCK: drv_val[i] = src.frequency_locked_loop_one_lock;
        `GFD_FN_LOOP2_LOCK: drv_val[i] = src.frequency_locked_loop_two_lock;
        `GFD_FN_LOOP1_OK: drv_val[i] = src.frequency_locked_loop_one_ok;
        `GFD_FN_LOOP2_OK: drv_val[i] = src.frequency_locked_loop_two_ok;
        `GFD_FN_WSEQ: drv_val[i] = src.write_sequencer_done;
        `GFD_FN_ADDRERR: drv_val[i] = src.address_error;
        `GFD_FN_RC1LK: drv_val[i] = src.rate_converter_one_lock;
        `GFD_FN_RC2LK: drv_val[i] = src.rate_converter_two_lock;
        default:
        begin
          // code 00h and undefined codes
          drv_en[i] = 1'b0;
          drv_val[i] = 1'b0;
        end
      endcase
      // every driven function inverts, the level output included
      drv_val[i] = drv_val[i] ^ cfg_q[i].output_polarity_invert;
    end
  end

  always_comb
  begin
    for (int i = 0; i < NPINS; i++)
    begin
      // open drain only pulls low
      pin_out[i] = drv_val[i];
      pin_oe[i] = drv_en[i] && !(cfg_q[i].output_drive_type && drv_val[i]);
    end
  end
endmodule : gfd_top

/* gfd_checker.sv */
`timescale 1ns/1ps
`include "gfd_consts.svh"
module gfd_checker
  import gfd_pkg::*;
#(
  parameter int NPINS = 2
)(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // sources, pins, interrupt
  input wire gfd_src_t src,
  input wire logic [NPINS-1:0] pin_in,
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic irq
);
  // =====================================================================
  // shadow of pin 1 control and irq mask, snooped off the bus
  logic ap_q, ap_d, wr_q, wr_d;
  logic [11:0] a_q, a_d;
  logic [15:0] c_q, c_d;
  logic [1:0] m_q, m_d;
  logic [16:0] sb;
  logic [4:0] idx;
  logic known;
  always_comb
  begin
    ap_d = hsel && hready && htrans[1];
    wr_d = hwrite;
    a_d = haddr[11:0];
    c_d = c_q;
    m_d = m_q;
    if (ap_q && wr_q && a_q == `GFD_PIN1_CTRL_ADDR)
      c_d = hwdata[15:0];
    if (ap_q && wr_q && a_q == `GFD_IRQ_MASK_ADDR)
      m_d = hwdata[1:0];
    sb = src;
    known = 1'b1;
    case (c_q[6:0])
      7'h02: idx = 5'd16;
      7'h03: idx = 5'd15;
      7'h04: idx = 5'd14;
      7'h05: idx = 5'd13;
      7'h06: idx = 5'd12;
      7'h08: idx = 5'd11;
      7'h09: idx = 5'd10;
      7'h0a: idx = 5'd9;
      7'h0b: idx = 5'd8;
      7'h0c: idx = 5'd7;
      7'h0d: idx = 5'd6;
      7'h0f: idx = 5'd5;
      7'h10: idx = 5'd4;
      7'h15: idx = 5'd3;
      7'h16: idx = 5'd2;
      7'h1a: idx = 5'd1;
      7'h1b: idx = 5'd0;
      default:
      begin
        idx = 5'd0;
        known = 1'b0;
      end
    endcase
  end
  // mask assumed open until written, so the irq check never guesses a reset value
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_q <= 1'b0;
      wr_q <= 1'b0;
      a_q <= 12'h000;
      c_q <= 16'h0101;
      m_q <= 2'h3;
    end
    else
    begin
      ap_q <= ap_d;
      wr_q <= wr_d;
      a_q <= a_d;
      c_q <= c_d;
      m_q <= m_d;
    end
  end
  // =====================================================================
  // properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence wr_lvl_s;
    hsel && hready && htrans[1] && hwrite && haddr[11:0] == 12'h000
    ##1 hwdata[6:0] == 7'h01 && !hwdata[15] && hwdata[10:9] == 2'b00;
  endsequence
  sequence rd_s(logic [11:0] ad);
    hsel && hready && htrans[1] && !hwrite && haddr[11:0] == ad ##1 1'b1;
  endsequence
  ready_high_a: assert property (hreadyout && !hresp)
    else $error("slave stalled or answered with an error");
  route_source_a: assert property (known && !c_q[15] && !c_q[9] |->
    pin_oe[0] && pin_out[0] == (sb[idx] ^ c_q[10]))
    else $error("pin 1 does not follow its selected source");
  no_function_a: assert property (!known && c_q[6:0] != 7'h01 |-> !pin_oe[0])
    else $error("pin 1 driven with no function selected");
  level_write_a: assert property (wr_lvl_s |=> pin_oe[0] && pin_out[0] == $past(hwdata[11]))
    else $error("pin 1 level not driven after write");
  input_dir_a: assert property (c_q[6:0] == 7'h01 && c_q[15] |-> !pin_oe[0])
    else $error("pin 1 driven while set as input");
  open_drain_a: assert property (c_q[6:0] == 7'h01 && !c_q[15] && c_q[9] |->
    pin_oe[0] == !(c_q[11] ^ c_q[10]) && !(pin_oe[0] && pin_out[0]))
    else $error("open-drain pin 1 drives high");
  unmapped_read_a: assert property (rd_s(12'h100) |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  read_back_a: assert property (rd_s(12'h000) |->
    {hrdata[15], hrdata[10:8], hrdata[6:0]} == {c_q[15], c_q[10:8], c_q[6:0]})
    else $error("pin 1 control reads back wrong");
  irq_masked_a: assert property (m_q == 2'b00 && $past(m_q) == 2'b00 |-> !irq)
    else $error("interrupt raised with all events masked");
endmodule : gfd_checker

/* gfd_pin_partner.sv */
`timescale 1ns/1ps
module gfd_pin_partner
  import gfd_pkg::*;
#(
  parameter int NPINS = 2
)(
  // clock
  input wire logic hclk,
  // pins
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe,
  output logic [NPINS-1:0] pin_in
);
  logic [NPINS-1:0] btn_en = '0;
  logic [NPINS-1:0] btn = '0;
  // released lines sit at the board pull-up, which open-drain relies on
  always_comb
    for (int i = 0; i < NPINS; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : (btn_en[i] ? btn[i] : 1'b1);
  // new level on pin i after n bounces, each g cycles at v then g cycles at !v
  task automatic press(input int i, input logic v, input int n, input int g);
    btn_en[i] <= 1'b1;
    repeat (n)
    begin
      btn[i] <= v;
      repeat (g) @(posedge hclk);
      btn[i] <= !v;
      repeat (g) @(posedge hclk);
    end
    btn[i] <= v;
  endtask : press
endmodule : gfd_pin_partner

/* gfd_top_tb_top.sv */
`timescale 1ns/1ps
module gfd_top_tb_top;
  import gfd_pkg::*;
  localparam int TK = 10;
  typedef struct packed { logic [31:0] v; logic [31:0] m; } gfd_exp_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hready, hresp, irq;
  gfd_src_t src = '0;
  logic [1:0] pin_in, pin_out, pin_oe;
  logic rph = 1'b0;
  int fail_count = 0;
  int compares = 0;
  gfd_exp_t expq[$];
  gfd_exp_t e;
  logic [6:0] fns [17] = '{7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h08, 7'h09, 7'h0a, 7'h0b,
    7'h0c, 7'h0d, 7'h0f, 7'h10, 7'h15, 7'h16, 7'h1a, 7'h1b};
  logic [6:0] nfs [6] = '{7'h00, 7'h07, 7'h0e, 7'h11, 7'h1c, 7'h7f};
  int nt [3] = '{1, 15, 30};
  always #5 hclk = !hclk;
  gfd_top #(.TICK_CYCLES(TK)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready, .hwdata, .hrdata, .hreadyout(hready), .hresp, .src, .pin_in, .pin_out, .pin_oe,
    .irq);
  gfd_pin_partner u_pp (.hclk, .pin_out, .pin_oe, .pin_in);
  // =====================================================================
  // bus master and comparison
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : xfer
  task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m);
    expq.push_back('{v: v & m, m: m});
    xfer(1'b0, a, 32'h0);
  endtask : rd
  function automatic logic [31:0] pv();
    return {28'h0, pin_oe, pin_out};
  endfunction : pv
  // read data is judged in the cycle it stands, against the oldest note
  always @(posedge hclk)
  begin
    if (rph)
    begin
      e = expq.pop_front();
      check(hrdata & e.m, e.v);
    end
    rph <= hsel && htrans[1] && !hwrite && hready;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    summarize();
  end
  // =====================================================================
  // tests
  initial
  begin
    logic [31:0] c;
    logic [16:0] sb;
    logic [1:0] r;
    logic v;
    void'($urandom(78118));
    repeat (16) @(posedge hclk);
    check(pv(), 32'hc);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(12'h000, 32'h0000_0101, 32'h0000_8f7f);
    rd(12'h004, 32'h0000_0101, 32'h0000_8f7f);
    rd(12'hc10, 32'h0000_1000, 32'h0000_f000);
    xfer(1'b1, 12'h100, 32'hffff_ffff);
    rd(12'h100, 32'h0, 32'hffff_ffff);
    $display("reset and map test done");
    for (int k = 0; k < 17; k++)
    begin
      r = 2'($urandom);
      xfer(1'b1, 12'h000, {21'h0, r[0], 2'b01, 1'b0, fns[k]});
      xfer(1'b1, 12'h004, {21'h0, r[1], 2'b01, 1'b0, fns[k]});
      repeat (4)
      begin
        src <= gfd_src_t'($urandom);
        @(posedge hclk);
        sb = src;
        check(pv(), {28'h3, sb[16-k] ^ r[1], sb[16-k] ^ r[0]});
        check({31'h0, pin_out[1]}, {31'h0, sb[16-k] ^ r[1]});
      end
    end
    foreach (nfs[k])
    begin
      xfer(1'b1, 12'h000, 32'h100 | nfs[k]);
      @(posedge hclk);
      check({31'h0, pin_oe[0]}, 32'h0);
    end
    $display("function select test done");
    for (int k = 0; k < 8; k++)
    begin
      c = {20'h0, k[0], k[1], k[2], 9'h101};
      xfer(1'b1, 12'h000, c);
      rd(12'h000, c & 32'hf7ff, 32'h8fff);
      v = k[0] ^ k[1];
      check({30'h0, pin_oe[0], pin_out[0] & pin_oe[0]},
        k[2] ? {30'h0, !v, 1'b0} : {30'h0, 1'b1, v});
      check({31'h0, pin_in[0]}, {31'h0, v});
    end
    $display("level and drive test done");
    u_pp.press(0, 1'b1, 0, 0);
    xfer(1'b1, 12'h000, 32'h8101);
    xfer(1'b1, 12'h024, 32'h1);
    repeat (40 * TK) @(posedge hclk);
    v = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'b1, 12'hc10, {16'h0, 4'(i), 12'h0});
      xfer(1'b1, 12'h020, 32'h3);
      v = !v;
      u_pp.press(0, v, 3, 4);
      if (nt[i] > 2)
      begin
        repeat ((nt[i] - 2) * TK) @(posedge hclk);
        rd(12'h000, {20'h0, !v, 11'h0}, 32'h800);
      end
      repeat (4 * TK) @(posedge hclk);
      rd(12'h000, {20'h0, v, 11'h0}, 32'h800);
      rd(12'h020, 32'h1, 32'h1);
      check({31'h0, irq}, 32'h1);
    end
    xfer(1'b1, 12'h024, 32'h0);
    @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    xfer(1'b1, 12'h024, 32'h1);
    @(posedge hclk);
    check({31'h0, irq}, 32'h1);
    xfer(1'b1, 12'h020, 32'h1);
    @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    rd(12'h020, 32'h0, 32'h1);
    $display("debounce and interrupt test done");
    xfer(1'b1, 12'h000, 32'h8001);
    u_pp.press(0, !v, 0, 0);
    repeat (4) @(posedge hclk);
    rd(12'h000, {20'h0, !v, 11'h0}, 32'h800);
    $display("debounce bypass test done");
    summarize();
  end
endmodule : gfd_top_tb_top
bind gfd_top gfd_checker #(.NPINS(NPINS)) u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .src, .pin_in, .pin_out,
  .pin_oe, .irq);
